// >>> logic/host_port_pkg.sv
// Package for the host port ready handshake block.
// Assumes a single 25 MHz clock and synchronous host pins.
package host_port_pkg;

  // ----------------------------------------
  // Access type encodings
  // ----------------------------------------
  localparam logic [1:0] SEL_CONTROL = 2'h0;
  localparam logic [1:0] SEL_DATA_INC = 2'h1;
  localparam logic [1:0] SEL_ADDRESS = 2'h2;
  localparam logic [1:0] SEL_DATA_FIXED = 2'h3;

  // ----------------------------------------
  // Sizes and reset values
  // ----------------------------------------
  localparam int FIFO_WORDS = 8;
  localparam logic [31:0] ADDR_RESET = 32'h00000000;
  localparam logic [31:0] CTRL_RESET = 32'h00000000;
  localparam logic [3:0] FETCH_LATENCY = 4'h3;

  // Pins of the host side, before the strobes are combined with chip select
  typedef struct packed {
    logic host_chip_select_n;
    logic data_strobe_one;
    logic data_strobe_two;
    logic read_write_select;
    logic halfword_select;
    logic access_type_select_a;
    logic access_type_select_b;
  } host_ctrl_s;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_STALL = 4'b0010,
    ST_DONE = 4'b0100,
    ST_FETCH = 4'b1000
  } port_state_e;

endpackage

// >>> logic/host_port_ready_handshake.sv
// Ready/wait handshake of a 16-bit multiplexed host port with 8-word read and write FIFOs.
// Assumes host pins are synchronous to clock_i; the system bus side is a simple word port.
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - Combined strobe is NOT(strobe one XOR strobe two) OR chip select.
// - Chip select high forces ready low.
// - Back-to-back address writes may stall ready.
// - Address write after read-ahead command stalls until read_ahead_command resolves.
// - Data write with write FIFO full or flushing stalls second half until space.
// - Address write with write FIFO not empty stalls until drained.
// - All other writes keep ready low.
// - Incrementing data read without FIFO data stalls first half only.
// - Non-incrementing data read stalls first half while fetching.
// - Incrementing data read with FIFO data never stalls.
// - Non-incrementing second half read never stalls.
// - Control and address reads never stall.
// - Resident read data is driven promptly after strobe.
// - Separate eight-word read and write FIFOs toward the system bus.
// - Address optionally increments after each data access.
module host_port_ready_handshake
  import host_port_pkg::*;
#(
  parameter int DEPTH = FIFO_WORDS
)
(
  input wire logic clock_i, // 25 MHz clock
  input wire logic rst_i, // Async reset, active high
  input wire host_ctrl_s host_ctrl_i, // Host select and strobe pins
  input wire logic [15:0] host_data_bus_i, // Host data in
  output logic [15:0] host_data_bus_o, // Host data out
  output logic host_data_bus_oe_o, // Host data drive enable
  output logic host_ready_n_o, // Ready, low is ready
  input wire logic read_ahead_command_i, // Read_ahead_command request
  input wire logic write_flush_i, // Write FIFO flush in progress
  output logic sys_wr_valid_o, // Write word to system bus
  output logic [31:0] sys_wr_addr_o, // Write address
  output logic [31:0] sys_wr_data_o, // Write data
  input wire logic sys_wr_ready_i, // System bus takes write
  output logic sys_rd_req_o, // Read request to system bus
  output logic [31:0] sys_rd_addr_o, // Read address
  input wire logic sys_rd_valid_i, // Read data returned
  input wire logic [31:0] sys_rd_data_i, // Read data
  output logic [31:0] control_word_o // Host control register
);

  localparam int AW = $clog2(DEPTH);

  // ----------------------------------------
  // Strobe decode
  // ----------------------------------------
  logic strobe_n;
  logic strobe_act;
  logic [1:0] sel;
  logic is_read;
  logic second_half;
  // Combined strobe, active low
  assign strobe_n = ~(host_ctrl_i.data_strobe_one ^ host_ctrl_i.data_strobe_two)
    | host_ctrl_i.host_chip_select_n;
  assign strobe_act = ~strobe_n;
  assign sel = {host_ctrl_i.access_type_select_b, host_ctrl_i.access_type_select_a};
  assign is_read = host_ctrl_i.read_write_select;
  assign second_half = host_ctrl_i.halfword_select;

  // ----------------------------------------
  // State
  // ----------------------------------------
  port_state_e state_reg, state_next;
  logic strobe_prev_reg, strobe_prev_next;
  logic [31:0] addr_reg, addr_next;
  logic [31:0] ctrl_reg, ctrl_next;
  logic [15:0] low_half_reg, low_half_next;
  logic [31:0] hold_reg, hold_next;
  logic last_addr_wr_reg, last_addr_wr_next;
  logic read_ahead_command_reg, read_ahead_command_next;
  logic [15:0] dout_reg, dout_next;
  logic oe_reg, oe_next;
  logic rdreq_reg, rdreq_next;
  logic [31:0] rdaddr_reg, rdaddr_next;
  logic fetch_fixed_reg, fetch_fixed_next;
  logic held_reg, held_next;
  // Write FIFO
  logic [31:0] wmem [DEPTH];
  logic [31:0] waddr_mem [DEPTH];
  logic [AW:0] wcnt_reg, wcnt_next;
  logic [AW-1:0] wwp_reg, wwp_next, wrp_reg, wrp_next;
  // Read FIFO
  logic [31:0] rmem [DEPTH];
  logic [AW:0] rcnt_reg, rcnt_next;
  logic [AW-1:0] rwp_reg, rwp_next, rrp_reg, rrp_next;

  logic strobe_rise;
  logic wfull;
  logic push_w, pop_w, push_r, pop_r;
  logic stall;
  logic fetch_done;

  assign strobe_rise = strobe_act & ~strobe_prev_reg;
  assign wfull = (wcnt_reg == (AW+1)'(DEPTH));
  assign pop_w = sys_wr_valid_o & sys_wr_ready_i;
  assign fetch_done = rdreq_reg & sys_rd_valid_i;

  // Stall conditions sampled while the strobe is active
  always_comb
  begin
    stall = 1'b0;
    if (!is_read) begin
      if (sel == SEL_ADDRESS)
        stall = last_addr_wr_reg | read_ahead_command_reg | (wcnt_reg != '0);
      else if (sel == SEL_DATA_INC || sel == SEL_DATA_FIXED)
        stall = (wfull | write_flush_i) & second_half;
      else
        stall = 1'b0;
    end else begin
      if (sel == SEL_DATA_INC)
        stall = !second_half && rcnt_reg == '0;
      else if (sel == SEL_DATA_FIXED)
        stall = !second_half;
      else
        stall = 1'b0;
    end
  end

  // Next-state logic: one pass per half-word strobe
  always_comb
  begin
    state_next = state_reg;
    strobe_prev_next = strobe_act;
    addr_next = addr_reg;
    ctrl_next = ctrl_reg;
    low_half_next = low_half_reg;
    hold_next = hold_reg;
    last_addr_wr_next = last_addr_wr_reg;
    read_ahead_command_next = read_ahead_command_reg;
    dout_next = dout_reg;
    oe_next = strobe_act & is_read;
    rdreq_next = rdreq_reg;
    rdaddr_next = rdaddr_reg;
    fetch_fixed_next = fetch_fixed_reg;
    held_next = strobe_act & stall & (state_reg == ST_IDLE || state_reg == ST_STALL); // Keeps ready high until commit
    push_w = 1'b0;
    push_r = 1'b0;
    pop_r = 1'b0;
    if (fetch_done) begin
      rdreq_next = 1'b0;
      if (fetch_fixed_reg)
        hold_next = sys_rd_data_i;
      else
        push_r = 1'b1;
    end
    // Read-ahead fetches one word once the read FIFO is empty
    if (read_ahead_command_i && !rdreq_reg)
      read_ahead_command_next = 1'b1;
    if (read_ahead_command_reg && !rdreq_reg && rcnt_reg == '0 && !fetch_done) begin
      rdreq_next = 1'b1;
      rdaddr_next = addr_reg;
      fetch_fixed_next = 1'b0;
    end
    if (read_ahead_command_reg && fetch_done && !fetch_fixed_reg)
      read_ahead_command_next = 1'b0;
    // Words already waiting settle the read-ahead, so address writes are not held forever
    if (read_ahead_command_reg && !rdreq_reg && rcnt_reg != '0)
      read_ahead_command_next = 1'b0;
    // One held cycle lets the last address update settle, then the hold is dropped
    if (state_reg == ST_STALL && last_addr_wr_reg)
      last_addr_wr_next = 1'b0;
    case (state_reg)
      ST_IDLE:
      begin
        if (strobe_rise)
          state_next = ST_STALL;
      end
      ST_STALL:
      begin
        if (!strobe_act)
          state_next = ST_IDLE;
        else if (!stall) begin
          state_next = ST_DONE;
          // Access takes effect as ready goes low
          if (!is_read) begin
            if (!second_half)
              low_half_next = host_data_bus_i;
            else if (sel == SEL_CONTROL)
              ctrl_next = {host_data_bus_i, low_half_reg};
            else if (sel == SEL_ADDRESS) begin
              addr_next = {host_data_bus_i, low_half_reg};
              last_addr_wr_next = 1'b1;
            end else begin
              push_w = 1'b1;
              if (sel == SEL_DATA_INC)
                addr_next = addr_reg + 32'h00000004;
            end
            if (sel != SEL_ADDRESS && second_half)
              last_addr_wr_next = 1'b0;
          end else begin
            last_addr_wr_next = 1'b0;
            if (sel == SEL_CONTROL)
              dout_next = second_half ? ctrl_reg[31:16] : ctrl_reg[15:0];
            else if (sel == SEL_ADDRESS)
              dout_next = second_half ? addr_reg[31:16] : addr_reg[15:0];
            else if (sel == SEL_DATA_INC && !second_half) begin
              hold_next = rmem[rrp_reg];
              dout_next = rmem[rrp_reg][15:0];
              pop_r = 1'b1;
              addr_next = addr_reg + 32'h00000004;
            end else
              dout_next = hold_reg[31:16];
          end
        end else if (is_read && sel == SEL_DATA_FIXED && !rdreq_reg) begin
          state_next = ST_FETCH;
          rdreq_next = 1'b1;
          rdaddr_next = addr_reg;
          fetch_fixed_next = 1'b1;
        end else if (is_read && sel == SEL_DATA_INC && !rdreq_reg) begin
          rdreq_next = 1'b1; // Fetch on demand
          rdaddr_next = addr_reg;
          fetch_fixed_next = 1'b0;
        end
      end
      ST_FETCH:
      begin
        if (fetch_done) begin
          state_next = ST_DONE;
          dout_next = sys_rd_data_i[15:0];
        end
      end
      ST_DONE:
      begin
        if (!strobe_act)
          state_next = ST_IDLE;
      end
      default:
        state_next = ST_IDLE;
    endcase
  end

  // Ready: released by chip select high or when access completes
  always_comb
  begin
    if (host_ctrl_i.host_chip_select_n)
      host_ready_n_o = 1'b0;
    else if (state_reg == ST_STALL)
      host_ready_n_o = stall | held_reg;
    else if (state_reg == ST_FETCH)
      host_ready_n_o = 1'b1;
    else
      host_ready_n_o = strobe_rise & stall;
  end

  // FIFO pointer arithmetic
  always_comb
  begin
    wwp_next = push_w ? AW'(wwp_reg + 1'b1) : wwp_reg;
    wrp_next = pop_w ? AW'(wrp_reg + 1'b1) : wrp_reg;
    wcnt_next = (AW+1)'(wcnt_reg + {{AW{1'b0}}, push_w} - {{AW{1'b0}}, pop_w});
    rwp_next = push_r ? AW'(rwp_reg + 1'b1) : rwp_reg;
    rrp_next = pop_r ? AW'(rrp_reg + 1'b1) : rrp_reg;
    rcnt_next = (AW+1)'(rcnt_reg + {{AW{1'b0}}, push_r} - {{AW{1'b0}}, pop_r});
  end

  // FIFO storage, eight words each way
  always_ff @(posedge clock_i)
  begin
    if (push_w) begin
      wmem[wwp_reg] <= {host_data_bus_i, low_half_reg};
      waddr_mem[wwp_reg] <= addr_reg;
    end
    if (push_r)
      rmem[rwp_reg] <= sys_rd_data_i;
  end

  // Registered state
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      strobe_prev_reg <= 1'b0;
      addr_reg <= ADDR_RESET;
      ctrl_reg <= CTRL_RESET;
      low_half_reg <= 16'h0000;
      hold_reg <= 32'h00000000;
      last_addr_wr_reg <= 1'b0;
      read_ahead_command_reg <= 1'b0;
      dout_reg <= 16'h0000;
      oe_reg <= 1'b0;
      rdreq_reg <= 1'b0;
      rdaddr_reg <= 32'h00000000;
      fetch_fixed_reg <= 1'b0;
      held_reg <= 1'b0;
      wcnt_reg <= '0;
      wwp_reg <= '0;
      wrp_reg <= '0;
      rcnt_reg <= '0;
      rwp_reg <= '0;
      rrp_reg <= '0;
    end else begin
      state_reg <= state_next;
      strobe_prev_reg <= strobe_prev_next;
      addr_reg <= addr_next;
      ctrl_reg <= ctrl_next;
      low_half_reg <= low_half_next;
      hold_reg <= hold_next;
      last_addr_wr_reg <= last_addr_wr_next;
      read_ahead_command_reg <= read_ahead_command_next;
      dout_reg <= dout_next;
      oe_reg <= oe_next;
      rdreq_reg <= rdreq_next;
      rdaddr_reg <= rdaddr_next;
      fetch_fixed_reg <= fetch_fixed_next;
      held_reg <= held_next;
      wcnt_reg <= wcnt_next;
      wwp_reg <= wwp_next;
      wrp_reg <= wrp_next;
      rcnt_reg <= rcnt_next;
      rwp_reg <= rwp_next;
      rrp_reg <= rrp_next;
    end
  end

  // Outputs
  assign host_data_bus_o = dout_reg;
  assign host_data_bus_oe_o = oe_reg;
  assign sys_wr_valid_o = (wcnt_reg != '0);
  assign sys_wr_addr_o = waddr_mem[wrp_reg];
  assign sys_wr_data_o = wmem[wrp_reg];
  assign sys_rd_req_o = rdreq_reg;
  assign sys_rd_addr_o = rdaddr_reg;
  assign control_word_o = ctrl_reg;

endmodule

`default_nettype wire

// >>> tb/host_port_sva.sv
// Checker for the host port ready handshake block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/10ps
`default_nettype none

// ------------------------------
// Port relations
// ------------------------------
module host_port_sva
  import host_port_pkg::*;
#(
  parameter int DEPTH = FIFO_WORDS
)
(
  input wire logic clock_i, // Clock
  input wire logic rst_i, // Reset
  input wire host_ctrl_s host_ctrl_i, // Host pins
  input wire logic write_flush_i, // Flush busy
  input wire logic host_ready_n_o, // Ready, low
  input wire logic host_data_bus_oe_o, // Drive enable
  input wire logic sys_wr_valid_o, // Write word waiting
  input wire logic sys_rd_req_o // Fetch request
);
  logic stb;
  logic rd;
  logic hw;
  logic [1:0] sel;

  // Decoded strobe and selects
  assign stb = !host_ctrl_i.host_chip_select_n && (host_ctrl_i.data_strobe_one ^ host_ctrl_i.data_strobe_two);
  assign rd = host_ctrl_i.read_write_select;
  assign hw = host_ctrl_i.halfword_select;
  assign sel = {host_ctrl_i.access_type_select_b, host_ctrl_i.access_type_select_a};

  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);

  // Access starts, decided at the strobe's first cycle
  sequence s_fix_first;
    $rose(stb) && rd && sel == SEL_DATA_FIXED && !hw;
  endsequence
  sequence s_flush_wr;
    $rose(stb) && !rd && sel[0] && hw && write_flush_i ##1 write_flush_i [*3];
  endsequence
  sequence s_addr_busy;
    $rose(stb) && !rd && sel == SEL_ADDRESS && sys_wr_valid_o ##1 sys_wr_valid_o [*3];
  endsequence

  AST_CS_READY: assert property (host_ctrl_i.host_chip_select_n |-> !host_ready_n_o)
    else $error("ready high while deselected");
  AST_IDLE_READY: assert property (!stb [*2] |-> !host_ready_n_o)
    else $error("ready high without strobe");
  AST_REG_RD: assert property ($rose(stb) && rd && !sel[0] |-> ##[1:3] !host_ready_n_o)
    else $error("register read stalled");
  AST_REG_OE: assert property ($rose(stb) && rd && !sel[0] |-> ##[1:3] host_data_bus_oe_o)
    else $error("register read data not driven");
  AST_FIX_STALL: assert property (s_fix_first |-> ##[1:2] host_ready_n_o)
    else $error("fixed read first half not stalled");
  AST_FIX_FETCH: assert property (s_fix_first |-> ##[1:4] sys_rd_req_o)
    else $error("fixed read did not fetch");
  AST_FIX_SECOND: assert property ($rose(stb) && rd && sel == SEL_DATA_FIXED && hw |-> ##[1:3] !host_ready_n_o)
    else $error("fixed read second half stalled");
  AST_FLUSH_STALL: assert property (s_flush_wr |-> host_ready_n_o)
    else $error("data write not held during flush");
  AST_ADDR_DRAIN: assert property (s_addr_busy |-> host_ready_n_o)
    else $error("address write not held while write words wait");
  AST_READY_HOLD: assert property (stb && !host_ready_n_o && !$rose(stb) ##1 stb |-> !host_ready_n_o)
    else $error("ready withdrawn during strobe");
endmodule

bind host_port_ready_handshake host_port_sva #(.DEPTH(DEPTH)) u_sva (.clock_i(clock_i), .rst_i(rst_i),
  .host_ctrl_i(host_ctrl_i), .write_flush_i(write_flush_i), .host_ready_n_o(host_ready_n_o),
  .host_data_bus_oe_o(host_data_bus_oe_o), .sys_wr_valid_o(sys_wr_valid_o), .sys_rd_req_o(sys_rd_req_o));

`default_nettype wire

// >>> tb/sys_bus_model.sv
// System bus responder standing behind the host port.
// Assumes one request at a time and a held request until answered.
`timescale 1ns/10ps
`default_nettype none

// ------------------------------
// Bus responder
// ------------------------------
module sys_bus_model
#(
  parameter int LAT = 3
)
(
  input wire logic clock_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic hold_i, // Stall writes
  output logic wr_ready_o, // Write taken
  input wire logic rd_req_i, // Read request
  input wire logic [31:0] rd_addr_i, // Read address
  output logic rd_valid_o, // Read data strobe
  output logic [31:0] rd_data_o // Read data
);
  int cnt;
  logic busy;

  // Writes drain unless the bench holds them back
  assign wr_ready_o = !hold_i;

  // Answer LAT+1 cycles after taking a request; data toggles between answers so stale reads show
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt <= 0;
      busy <= 1'b0;
      rd_valid_o <= 1'b0;
      rd_data_o <= 32'h0;
    end
    else
    begin
      rd_valid_o <= 1'b0;
      rd_data_o <= ~rd_data_o;
      if (rd_req_i && !busy && !rd_valid_o)
      begin
        busy <= 1'b1;
        cnt <= LAT;
      end
      else if (busy && cnt > 0)
        cnt <= cnt - 1;
      else if (busy)
      begin
        busy <= 1'b0;
        rd_valid_o <= 1'b1;
        rd_data_o <= rd_addr_i ^ 32'hA5A55A5A;
      end
    end
  end
endmodule

`default_nettype wire

// >>> tb/tb.sv
// Self-checking bench for the host port ready handshake.
// Assumes the checker is bound and the bus responder answers reads.
`timescale 1ns/10ps
`default_nettype none

// ------------------------------
// Bench top
// ------------------------------
module tb;
  import host_port_pkg::*;
  logic clock_i, rst_i, rah, flush, hold, wv, wr_rdy, rq, rv, oe, rdy_n;
  host_ctrl_s hc;
  logic [15:0] din, dout, d;
  logic [31:0] wa, wd, ra, rdat, cw;
  int errors, tests_run;

  host_port_ready_handshake uut (.clock_i(clock_i), .rst_i(rst_i), .host_ctrl_i(hc), .host_data_bus_i(din),
    .host_data_bus_o(dout), .host_data_bus_oe_o(oe), .host_ready_n_o(rdy_n), .read_ahead_command_i(rah),
    .write_flush_i(flush), .sys_wr_valid_o(wv), .sys_wr_addr_o(wa), .sys_wr_data_o(wd),
    .sys_wr_ready_i(wr_rdy), .sys_rd_req_o(rq), .sys_rd_addr_o(ra), .sys_rd_valid_i(rv),
    .sys_rd_data_i(rdat), .control_word_o(cw));
  sys_bus_model bus (.clock_i(clock_i), .rst_i(rst_i), .hold_i(hold), .wr_ready_o(wr_rdy), .rd_req_i(rq),
    .rd_addr_i(ra), .rd_valid_o(rv), .rd_data_o(rdat));

  task automatic conclude;
    if (errors == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One half-word access; strobe held until ready is seen low
  task automatic acc(input logic r, h, input logic [1:0] s, input logic [15:0] w, input logic stl,
    input string nm);
    int n;
    int st;
    st = 0;
    @(posedge clock_i);
    hc <= '{1'b0, 1'b1, 1'b0, r, h, s[0], s[1]};
    din <= w;
    for (n = 0; n < 60; n++)
    begin
      @(negedge clock_i);
      if (rdy_n === 1'b1)
        st++;
      if (n >= 2 && rdy_n === 1'b0)
        break;
    end
    if (n == 60)
    begin
      errors++;
      conclude();
    end
    d = dout;
    @(posedge clock_i);
    hc <= '{1'b1, 1'b0, 1'b0, r, h, s[0], s[1]};
    if (stl !== 1'bx)
      chk(nm, {31'h0, stl}, {31'h0, st > 1});
  endtask

  // Register writes and reads, and deselect behaviour
  task automatic t_regs;
    acc(0, 0, SEL_CONTROL, 16'h0001, 0, "ctrl_wr_lo");
    acc(0, 1, SEL_CONTROL, 16'hC0DE, 0, "ctrl_wr_hi");
    chk("control_word", 32'hC0DE0001, cw);
    acc(1, 0, SEL_CONTROL, 16'h0, 0, "ctrl_rd_lo");
    chk("ctrl_rd_lo_data", 32'h0001, {16'h0, d});
    acc(1, 1, SEL_CONTROL, 16'h0, 0, "ctrl_rd_hi");
    chk("ctrl_rd_hi_data", 32'hC0DE, {16'h0, d});
    @(posedge clock_i);
    hc <= '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
    @(negedge clock_i);
    chk("ready_deselected", 32'h0, {31'h0, rdy_n});
    @(posedge clock_i);
    hc <= '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
  endtask

  // Data write held in the FIFO, then an address write that must wait
  task automatic t_write;
    hold <= 1'b1;
    acc(0, 0, SEL_ADDRESS, 16'h0100, 1'bx, "addr_lo");
    acc(0, 1, SEL_ADDRESS, 16'h0000, 1'bx, "addr_hi");
    acc(1, 0, SEL_ADDRESS, 16'h0, 0, "addr_rd_lo");
    chk("addr_rd_data", 32'h0100, {16'h0, d});
    acc(0, 0, SEL_DATA_INC, 16'h1234, 0, "data_wr_lo");
    acc(0, 1, SEL_DATA_INC, 16'hABCD, 0, "data_wr_hi");
    @(negedge clock_i);
    chk("wr_valid", 32'h1, {31'h0, wv});
    chk("wr_data", 32'hABCD1234, wd);
    chk("wr_addr", 32'h00000100, wa);
    fork
      begin
        repeat (8) @(posedge clock_i);
        hold <= 1'b0;
      end
    join_none
    acc(0, 0, SEL_ADDRESS, 16'h0200, 1, "addr_wait");
    acc(0, 1, SEL_ADDRESS, 16'h0000, 1'bx, "addr_wait_hi");
    chk("wr_drained", 32'h0, {31'h0, wv});
  endtask

  // Data write during a flush
  task automatic t_flush;
    flush <= 1'b1;
    acc(0, 0, SEL_DATA_FIXED, 16'h5555, 1'bx, "flush_lo");
    fork
      begin
        repeat (8) @(posedge clock_i);
        flush <= 1'b0;
      end
    join_none
    acc(0, 1, SEL_DATA_FIXED, 16'hAAAA, 1, "flush_hi");
  endtask

  // Fixed, incrementing and prefetched reads
  task automatic t_read;
    int n;
    acc(0, 0, SEL_ADDRESS, 16'h0300, 1'bx, "raddr_lo");
    acc(0, 1, SEL_ADDRESS, 16'h0000, 1'bx, "raddr_hi");
    acc(1, 0, SEL_DATA_FIXED, 16'h0, 1, "fix_lo");
    chk("fix_lo_data", 32'h595A, {16'h0, d});
    acc(1, 1, SEL_DATA_FIXED, 16'h0, 0, "fix_hi");
    chk("fix_hi_data", 32'hA5A5, {16'h0, d});
    acc(1, 0, SEL_DATA_INC, 16'h0, 1, "inc_lo");
    chk("inc_lo_data", 32'h595A, {16'h0, d});
    acc(1, 1, SEL_DATA_INC, 16'h0, 0, "inc_hi");
    @(posedge clock_i);
    rah <= 1'b1;
    @(posedge clock_i);
    rah <= 1'b0;
    for (n = 0; n < 40 && rq !== 1'b1; n++)
      @(negedge clock_i);
    if (n == 40)
    begin
      errors++;
      conclude();
    end
    for (n = 0; n < 40 && rq !== 1'b0; n++)
      @(negedge clock_i);
    chk("read_ahead_command_done", 32'h0, {31'h0, rq});
    acc(1, 0, SEL_DATA_INC, 16'h0, 0, "pre_lo");
    chk("pre_lo_data", 32'h595E, {16'h0, d});
    acc(1, 1, SEL_DATA_INC, 16'h0, 0, "pre_hi");
    chk("pre_hi_data", 32'hA5A5, {16'h0, d});
    @(posedge clock_i);
    rah <= 1'b1;
    @(posedge clock_i);
    rah <= 1'b0;
    acc(0, 0, SEL_ADDRESS, 16'h0400, 1, "addr_after_read_ahead_command");
    acc(0, 1, SEL_ADDRESS, 16'h0000, 1'bx, "addr_after_read_ahead_command_hi");
    acc(0, 0, SEL_ADDRESS, 16'h0500, 1, "addr_back_to_back");
    acc(0, 1, SEL_ADDRESS, 16'h0000, 1'bx, "addr_back_to_back_hi");
  endtask

  // Free-running clock
  initial
  begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end

  // Reset, then the scenarios in turn
  initial
  begin
    rst_i = 1'b1;
    hc = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
    din = 16'h0;
    rah = 1'b0;
    flush = 1'b0;
    hold = 1'b0;
    errors = 0;
    tests_run = 0;
    repeat (3) @(posedge clock_i);
    rst_i <= 1'b0;
    t_regs();
    t_write();
    t_flush();
    t_read();
    conclude();
  end
endmodule

`default_nettype wire
